// ===== pkg/swc_cfg.svh
// constants of the standby and wake controller: offsets, bit positions, reset values
// assumes inclusion by bare name from design files only
`ifndef SWC_CFG_SVH
`define SWC_CFG_SVH
// ********************
// register offsets
// ********************
`define SWC_OFF_CTRL      8'h00
`define SWC_OFF_WAKE_EN   8'h04
`define SWC_OFF_PORT_SEL  8'h08
`define SWC_OFF_IRQ_EN    8'h0C
`define SWC_OFF_STATUS    8'h10
`define SWC_OFF_PEND      8'h14
// ********************
// field positions
// ********************
`define SWC_CTRL_HALT     0
`define SWC_CTRL_HOLD     1
`define SWC_CTRL_SER_SO4  2
`define SWC_CTRL_T2_EVT   3
`define SWC_W_INT         0
`define SWC_W_T1          1
`define SWC_W_T2          2
`define SWC_W_BASE        3
`define SWC_W_SER         4
`define SWC_I_INT         0
`define SWC_I_T1          1
`define SWC_I_T2          2
`define SWC_I_SER         3
`define SWC_P_OVF         4
`define SWC_P_UNF         5
// ********************
// reset values
// ********************
`define SWC_CFG_RST       2'h0
`define SWC_WAKE_EN_RST   5'h00
`define SWC_PORT_SEL_RST  8'h00
`define SWC_IRQ_EN_RST    4'h0
`endif

// ===== pkg/swc_pkg.sv
// types of the standby and wake controller
// assumes the config header carries all numeric constants
package swc_pkg;
  // ********************
  // types
  // ********************
  typedef enum logic [1:0] {
    SWC_RUN  = 2'b00,
    SWC_HALT = 2'b01,
    SWC_HOLD = 2'b10,
    SWC_WAKE = 2'b11
  } swc_state_e;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } swc_apb_req_s;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } swc_apb_rsp_s;
endpackage : swc_pkg

// ===== hdl/swc_edge_det.sv
// edge detector for a group of synchronous pin levels
// assumes inputs already synchronous to clock
`timescale 1ns/10ps
module swc_edge_det #(
  parameter int WIDTH = 1,
  parameter int MODE  = 2   // 0 falling, 1 rising, 2 either
) (
  // clock and reset
  input  wire logic             clock,
  input  wire logic             sys_rst,
  // levels and detected edges
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] edge_o
);
  logic [WIDTH-1:0] prev_r;
  logic [WIDTH-1:0] prev_nxt;
  logic             primed_r;
  logic             primed_nxt;

  // first sample only primes, so reset never fakes an edge
  always_comb begin
    prev_nxt   = din;
    primed_nxt = 1'b1;
    if (!primed_r) begin
      edge_o = '0;
    end else if (MODE == 0) begin
      edge_o = prev_r & ~din;
    end else if (MODE == 1) begin
      edge_o = ~prev_r & din;
    end else begin
      edge_o = prev_r ^ din;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      prev_r   <= '0;
      primed_r <= 1'b0;
    end else begin
      prev_r   <= prev_nxt;
      primed_r <= primed_nxt;
    end
  end
endmodule : swc_edge_det

// ===== hdl/swc_stack_mem.sv
// return address memory, one write and one registered read port
// assumes the caller keeps the stack pointer and range checks
`timescale 1ns/10ps
module swc_stack_mem #(
  parameter int DEPTH = 8,
  parameter int WIDTH = 13
) (
  // clock and reset
  input  wire logic                     clock,
  input  wire logic                     sys_rst,
  // write port
  input  wire logic                     wr_en,
  input  wire logic [$clog2(DEPTH)-1:0] wr_addr,
  input  wire logic [WIDTH-1:0]         wr_data,
  // read port
  input  wire logic                     rd_en,
  input  wire logic [$clog2(DEPTH)-1:0] rd_addr,
  output logic      [WIDTH-1:0]         rd_data
);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [WIDTH-1:0] rd_nxt;

  // array carries no reset, only the read register does
  always_comb begin
    rd_nxt = rd_en ? mem_r[rd_addr] : rd_data;
  end

  always_ff @(posedge clock) begin
    if (wr_en) begin
      mem_r[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      rd_data <= '0;
    end else begin
      rd_data <= rd_nxt;
    end
  end
endmodule : swc_stack_mem

// ===== hdl/swc_top.sv
// standby and wake controller: halt and hold states, wake sources,
// interrupt factors with vectors, and the return address stack
// assumes APB master on the same clock and synchronous pin inputs
//
// How it works
// - halt stops execution, clocks and peripherals continue
// - halt exit sources enabled one by one
// - serial pins or serial_group_bit4, one selected
// - eight selectable port wake factors
// - hold stops every oscillator
// - hold exits only on listed sources
// - event counter mode forces bidir_port_m_bit4 input
// - five factors share four interrupt vectors
// - eight level stack keeps return addresses
// - external pin edge chosen at build time
`timescale 1ns/10ps
`include "swc_cfg.svh"
module swc_top #(
  parameter int   STACK_DEPTH = 8,
  parameter int   PC_W        = 13,
  parameter logic INT_RISING  = 1'b0
) (
  // clock and reset
  input  wire logic                 clock,
  input  wire logic                 sys_rst,
  // register bus
  input  wire swc_pkg::swc_apb_req_s apb_req,
  output swc_pkg::swc_apb_rsp_s      apb_rsp,
  // event sources
  input  wire logic                 ext_int_pin,
  input  wire logic [2:0]           serial_pins,
  input  wire logic                 serial_group_bit4,
  input  wire logic [3:0]           port_s_pins,
  input  wire logic [3:0]           port_k_pins,
  input  wire logic                 timer1_evt,
  input  wire logic                 timer2_evt,
  input  wire logic                 base_timer_evt,
  // processor core
  input  wire logic                 core_call,
  input  wire logic                 core_ret,
  input  wire logic [PC_W-1:0]      core_pc,
  output logic                      core_run,
  output logic                      osc_en,
  output logic                      irq_pulse,
  output logic [1:0]                irq_vec,
  output logic [PC_W-1:0]           ret_pc,
  output logic                      bidir_port_m_bit4_force_in
);
  localparam int AW = $clog2(STACK_DEPTH);
  localparam int SW = AW + 1;
  localparam logic [SW-1:0] SP_FULL = SW'(STACK_DEPTH);

  // ********************
  // event detection
  // ********************
  logic       int_evt;
  logic [2:0] ser_pin_evt;
  logic       so4_evt;
  logic [7:0] port_evt;

  // pin edge polarity fixed at build time
  swc_edge_det #(.WIDTH(1), .MODE(INT_RISING ? 1 : 0)) u_int_det (
    .clock  (clock),
    .sys_rst(sys_rst),
    .din    (ext_int_pin),
    .edge_o (int_evt)
  );
  swc_edge_det #(.WIDTH(4), .MODE(2)) u_ser_det (
    .clock  (clock),
    .sys_rst(sys_rst),
    .din    ({serial_group_bit4, serial_pins}),
    .edge_o ({so4_evt, ser_pin_evt})
  );
  swc_edge_det #(.WIDTH(8), .MODE(2)) u_port_det (
    .clock  (clock),
    .sys_rst(sys_rst),
    .din    ({port_k_pins, port_s_pins}),
    .edge_o (port_evt)
  );

  // ********************
  // registers and state
  // ********************
  swc_pkg::swc_state_e state_r, state_nxt;
  logic [1:0]    cfg_r, cfg_nxt;           // serial select, event counter mode
  logic [4:0]    wake_en_r, wake_en_nxt;
  logic [7:0]    port_sel_r, port_sel_nxt;
  logic [3:0]    irq_en_r, irq_en_nxt;
  logic [3:0]    pend_r, pend_nxt;
  logic          ovf_r, ovf_nxt, unf_r, unf_nxt;
  logic [SW-1:0] sp_r, sp_nxt;
  logic          core_run_nxt, osc_en_nxt, irq_pulse_nxt;
  logic [1:0]    irq_vec_nxt;
  logic          m4_nxt;
  swc_pkg::swc_apb_rsp_s rsp_nxt;

  logic       ser_sel, t2_evt_mode;
  logic       ser_evt, port_wake, halt_wake, hold_wake;
  logic [4:0] src, hold_mask;
  logic [3:0] irq_src, irq_ready;
  logic       irq_take, push, pop;
  logic [1:0] take_vec;
  logic       apb_wr, apb_setup;
  logic [AW-1:0] wr_addr, rd_addr;

  assign ser_sel     = cfg_r[0];
  assign t2_evt_mode = cfg_r[1];

  // ********************
  // wake and interrupt sources
  // ********************
  always_comb begin
    ser_evt   = ser_sel ? so4_evt : |ser_pin_evt;
    port_wake = |(port_evt & port_sel_r);
    src       = {ser_evt, base_timer_evt, timer2_evt, timer1_evt, int_evt};
    // timer 1 and the base timer need the oscillator, so hold drops them
    hold_mask = {1'b1, 1'b0, t2_evt_mode, 1'b0, 1'b1};
    halt_wake = |(src & wake_en_r) | port_wake;
    hold_wake = |(src & wake_en_r & hold_mask) | port_wake;
    irq_src   = {ser_evt, timer2_evt, timer1_evt, int_evt};
  end

  // ********************
  // bus decode
  // ********************
  assign apb_setup = apb_req.psel & ~apb_req.penable;
  assign apb_wr    = apb_req.psel & apb_req.penable & apb_rsp.pready & apb_req.pwrite;

  // answer is prepared in setup and shown for the one access cycle
  always_comb begin
    rsp_nxt = '0;
    if (apb_setup) begin
      rsp_nxt.pready = 1'b1;
      unique case (apb_req.paddr)
        `SWC_OFF_CTRL:     rsp_nxt.prdata = 32'({cfg_r, 2'h0});
        `SWC_OFF_WAKE_EN:  rsp_nxt.prdata = 32'(wake_en_r);
        `SWC_OFF_PORT_SEL: rsp_nxt.prdata = 32'(port_sel_r);
        `SWC_OFF_IRQ_EN:   rsp_nxt.prdata = 32'(irq_en_r);
        `SWC_OFF_STATUS:   rsp_nxt.prdata = 32'({sp_r, state_r});
        `SWC_OFF_PEND:     rsp_nxt.prdata = 32'({unf_r, ovf_r, pend_r});
        default:           rsp_nxt.pslverr = 1'b1;
      endcase
    end
  end

  // ********************
  // configuration
  // ********************
  always_comb begin
    cfg_nxt      = cfg_r;
    wake_en_nxt  = wake_en_r;
    port_sel_nxt = port_sel_r;
    irq_en_nxt   = irq_en_r;
    if (apb_wr) begin
      unique case (apb_req.paddr)
        `SWC_OFF_CTRL:     cfg_nxt = apb_req.pwdata[`SWC_CTRL_T2_EVT:`SWC_CTRL_SER_SO4];
        `SWC_OFF_WAKE_EN:  wake_en_nxt = apb_req.pwdata[4:0];
        `SWC_OFF_PORT_SEL: port_sel_nxt = apb_req.pwdata[7:0];
        `SWC_OFF_IRQ_EN:   irq_en_nxt = apb_req.pwdata[3:0];
        default:           ;
      endcase
    end
    m4_nxt = cfg_nxt[1];
  end

  // ********************
  // standby state machine
  // ********************
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      swc_pkg::SWC_RUN: begin
        if (apb_wr && apb_req.paddr == `SWC_OFF_CTRL) begin
          if (apb_req.pwdata[`SWC_CTRL_HOLD]) begin
            state_nxt = swc_pkg::SWC_HOLD;
          end else if (apb_req.pwdata[`SWC_CTRL_HALT]) begin
            state_nxt = swc_pkg::SWC_HALT;
          end
        end
      end
      swc_pkg::SWC_HALT: begin
        if (halt_wake) begin
          state_nxt = swc_pkg::SWC_RUN;
        end
      end
      swc_pkg::SWC_HOLD: begin
        if (hold_wake) begin
          state_nxt = swc_pkg::SWC_WAKE;
        end
      end
      swc_pkg::SWC_WAKE: state_nxt = swc_pkg::SWC_RUN;
    endcase
    // clocks run in halt, only the core is frozen
    core_run_nxt = (state_nxt == swc_pkg::SWC_RUN);
    osc_en_nxt   = (state_nxt != swc_pkg::SWC_HOLD);
  end

  // ********************
  // interrupts and stack
  // ********************
  always_comb begin
    irq_ready = pend_r & irq_en_r;
    take_vec  = 2'h0;
    for (int i = 3; i >= 0; i--) begin
      if (irq_ready[i]) begin
        take_vec = 2'(i);
      end
    end
    // entry waits for a free stack slot and a quiet core port
    irq_take = core_run && |irq_ready && !core_call && !core_ret
               && sp_r != SP_FULL;
    irq_pulse_nxt = irq_take;
    irq_vec_nxt   = irq_take ? take_vec : irq_vec;
    pend_nxt = pend_r;
    ovf_nxt  = ovf_r;
    unf_nxt  = unf_r;
    if (apb_wr && apb_req.paddr == `SWC_OFF_PEND) begin
      pend_nxt = pend_nxt & ~apb_req.pwdata[3:0];
      ovf_nxt  = ovf_nxt & ~apb_req.pwdata[`SWC_P_OVF];
      unf_nxt  = unf_nxt & ~apb_req.pwdata[`SWC_P_UNF];
    end
    if (irq_take) begin
      pend_nxt[take_vec] = 1'b0;
    end
    pend_nxt = pend_nxt | irq_src;                               // set wins
    push = (core_call || irq_take) && sp_r != SP_FULL;
    pop  = core_ret && !core_call && sp_r != '0;
    if (core_call && sp_r == SP_FULL) begin
      ovf_nxt = 1'b1;
    end
    if (core_ret && !core_call && sp_r == '0) begin
      unf_nxt = 1'b1;
    end
    sp_nxt  = push ? sp_r + SW'(1) : (pop ? sp_r - SW'(1) : sp_r);
    wr_addr = sp_r[AW-1:0];
    rd_addr = AW'(sp_r - SW'(1));
  end

  swc_stack_mem #(.DEPTH(STACK_DEPTH), .WIDTH(PC_W)) u_stack (
    .clock  (clock),
    .sys_rst(sys_rst),
    .wr_en  (push),
    .wr_addr(wr_addr),
    .wr_data(core_pc),
    .rd_en  (pop),
    .rd_addr(rd_addr),
    .rd_data(ret_pc)
  );

  // ********************
  // registers
  // ********************
  // reset is the one exit that needs no enable
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      state_r    <= swc_pkg::SWC_RUN;
      cfg_r      <= `SWC_CFG_RST;
      wake_en_r  <= `SWC_WAKE_EN_RST;
      port_sel_r <= `SWC_PORT_SEL_RST;
      irq_en_r   <= `SWC_IRQ_EN_RST;
      pend_r     <= 4'h0;
      ovf_r      <= 1'b0;
      unf_r      <= 1'b0;
      sp_r       <= '0;
      core_run   <= 1'b1;
      osc_en     <= 1'b1;
      irq_pulse  <= 1'b0;
      irq_vec    <= 2'h0;
      bidir_port_m_bit4_force_in <= 1'b0;
      apb_rsp    <= '0;
    end else begin
      state_r    <= state_nxt;
      cfg_r      <= cfg_nxt;
      wake_en_r  <= wake_en_nxt;
      port_sel_r <= port_sel_nxt;
      irq_en_r   <= irq_en_nxt;
      pend_r     <= pend_nxt;
      ovf_r      <= ovf_nxt;
      unf_r      <= unf_nxt;
      sp_r       <= sp_nxt;
      core_run   <= core_run_nxt;
      osc_en     <= osc_en_nxt;
      irq_pulse  <= irq_pulse_nxt;
      irq_vec    <= irq_vec_nxt;
      bidir_port_m_bit4_force_in <= m4_nxt;
      apb_rsp    <= rsp_nxt;
    end
  end

  // ********************
  // assertions
  // ********************
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  AST_HALT_CLOCKS: assert property (state_r == swc_pkg::SWC_HALT |-> osc_en && !core_run)
    else $error("halt must keep clocks and stop the core");
  AST_HALT_EXIT: assert property (state_r == swc_pkg::SWC_HALT && halt_wake
      |=> state_r == swc_pkg::SWC_RUN && core_run)
    else $error("enabled halt source did not resume");
  AST_SER_SO4: assert property (ser_sel && so4_evt |=> pend_r[`SWC_I_SER])
    else $error("serial_group_bit4 edge lost");
  AST_PORT_WAKE: assert property (state_r == swc_pkg::SWC_HALT && |(port_evt & port_sel_r)
      |=> state_r == swc_pkg::SWC_RUN)
    else $error("selected port edge did not wake");
  AST_HOLD_OSC: assert property (state_r == swc_pkg::SWC_HOLD |-> !osc_en && !core_run)
    else $error("oscillator running in hold");
  AST_HOLD_STAYS: assert property (state_r == swc_pkg::SWC_HOLD && !hold_wake
      |=> state_r == swc_pkg::SWC_HOLD)
    else $error("hold left without a hold source");
  AST_M4_FORCE: assert property (apb_wr && apb_req.paddr == `SWC_OFF_CTRL
      && apb_req.pwdata[`SWC_CTRL_T2_EVT] |=> bidir_port_m_bit4_force_in)
    else $error("event counter mode did not force input");
  AST_IRQ_PUSH: assert property (irq_take |=> irq_pulse && sp_r == $past(sp_r) + SW'(1))
    else $error("interrupt entry without vector or push");
  AST_POP: assert property (core_ret && !core_call && sp_r != '0
      |=> sp_r == $past(sp_r) - SW'(1))
    else $error("return did not pop stack");
  AST_INT_PEND: assert property (int_evt |=> pend_r[`SWC_I_INT])
    else $error("pin edge not recorded");
  AST_HOLD_WAKE: assert property (state_r == swc_pkg::SWC_HOLD && hold_wake
      |=> osc_en && !core_run ##1 core_run)
    else $error("hold wake sequence wrong");

  COV_HALT_WAKE: cover property (state_r == swc_pkg::SWC_HALT ##1 state_r == swc_pkg::SWC_RUN);
  COV_HOLD_WAKE: cover property (state_r == swc_pkg::SWC_WAKE ##1 core_run);
  COV_IRQ:       cover property (irq_pulse && irq_vec == 2'h3);
  COV_FULL:      cover property (sp_r == SP_FULL);
endmodule : swc_top

// ===== tb/swc_core_model.sv
// core stand-in: turns bench requests into call and return strobes
// assumes the controller gates execution through core_run
`timescale 1ns/10ps
module swc_core_model #(
  parameter int PC_W = 13
) (
  // clock and reset
  input  wire logic            clock,
  input  wire logic            sys_rst,
  // requests from the bench
  input  wire logic            do_call,
  input  wire logic            do_ret,
  input  wire logic [PC_W-1:0] pc_in,
  // controller side
  input  wire logic            core_run,
  output logic                 core_call,
  output logic                 core_ret,
  output logic      [PC_W-1:0] core_pc
);
  // a stalled core issues nothing; idle pc keeps changing so stale values show
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      core_call <= 1'b0;
      core_ret  <= 1'b0;
      core_pc   <= '0;
    end else begin
      core_call <= do_call & core_run;
      core_ret  <= do_ret & core_run & ~do_call;
      core_pc   <= do_call ? pc_in : ~core_pc;
    end
  end
endmodule : swc_core_model

// ===== tb/swc_top_bench.sv
// self-checking bench of the standby and wake controller
// assumes the core model beside it; assertions live in the design
`timescale 1ns/10ps
module swc_top_bench;
  logic                  clock = 1'b0;
  logic                  sys_rst = 1'b1;
  swc_pkg::swc_apb_req_s req = '0;
  swc_pkg::swc_apb_rsp_s rsp;
  logic                  ext_int_pin = 1'b1;
  logic [2:0]            serial_pins = 3'h0;
  logic                  serial_group_bit4 = 1'b0;
  logic [3:0]            port_s_pins = 4'h0;
  logic [3:0]            port_k_pins = 4'h0;
  logic                  timer1_evt = 1'b0, timer2_evt = 1'b0, base_timer_evt = 1'b0;
  logic                  do_call = 1'b0, do_ret = 1'b0, ret_seen = 1'b0, last_err;
  logic [12:0]           pc_in = 13'h0000;
  logic                  core_call, core_ret, core_run, osc_en, irq_pulse, force_in;
  logic [12:0]           core_pc, ret_pc;
  logic [1:0]            irq_vec;
  logic [31:0]           seed = 32'h00006050;
  logic [31:0]           rd_q[$], ret_q[$], irq_q[$];
  int                    fails = 0, tests_run = 0, cycles = 0;

  // 250 MHz clock
  always #2 clock = ~clock;

  swc_top #(.STACK_DEPTH(8), .PC_W(13), .INT_RISING(1'b0)) dut (
    .clock(clock), .sys_rst(sys_rst), .apb_req(req), .apb_rsp(rsp),
    .ext_int_pin(ext_int_pin), .serial_pins(serial_pins),
    .serial_group_bit4(serial_group_bit4), .port_s_pins(port_s_pins),
    .port_k_pins(port_k_pins), .timer1_evt(timer1_evt), .timer2_evt(timer2_evt),
    .base_timer_evt(base_timer_evt), .core_call(core_call), .core_ret(core_ret),
    .core_pc(core_pc), .core_run(core_run), .osc_en(osc_en), .irq_pulse(irq_pulse),
    .irq_vec(irq_vec), .ret_pc(ret_pc), .bidir_port_m_bit4_force_in(force_in));

  swc_core_model #(.PC_W(13)) core (
    .clock(clock), .sys_rst(sys_rst), .do_call(do_call), .do_ret(do_ret),
    .pc_in(pc_in), .core_run(core_run), .core_call(core_call),
    .core_ret(core_ret), .core_pc(core_pc));

  // ********************
  // shared tasks
  // ********************
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic close_out();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : close_out

  // one transfer; the wait is open-ended, only the run timeout ends it
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    req.psel <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite <= w;
    req.paddr <= a;
    req.pwdata <= d;
    @(posedge clock);
    req.penable <= 1'b1;
    do @(posedge clock); while (rsp.pready !== 1'b1);
    last_err = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask : apb

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rd_q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask : rd

  // source k: 0 int pin, 1-3 timers, 4 serial pins, 5 serial_group_bit4, 8+i port select i
  task automatic fire(input int k);
    @(posedge clock);
    case (k)
      0: ext_int_pin <= ~ext_int_pin;
      1: timer1_evt <= 1'b1;
      2: timer2_evt <= 1'b1;
      3: base_timer_evt <= 1'b1;
      4: serial_pins <= serial_pins ^ (3'h1 << (xs() % 3));
      5: serial_group_bit4 <= ~serial_group_bit4;
      default: {port_k_pins, port_s_pins} <= {port_k_pins, port_s_pins} ^ (8'h01 << (k - 8));
    endcase
    @(posedge clock);
    {timer1_evt, timer2_evt, base_timer_evt} <= 3'h0;
  endtask : fire

  task automatic wt(input bit osc, input logic v);
    int n;
    n = 0;
    while ((osc ? osc_en : core_run) !== v && n < 40) begin
      @(posedge clock);
      n++;
    end
    // names kept apart so the message never carries padding from a mixed-width select
    if (osc) chk("osc_en", {31'h0, v}, {31'h0, osc_en});
    else chk("core_run", {31'h0, v}, {31'h0, core_run});
  endtask : wt

  // enter standby, show that a wrong source is ignored, then wake
  task automatic stby(input logic [31:0] cmd, input int bad, input int good);
    apb(1'b1, 8'h00, cmd);
    wt(1'b0, 1'b0);
    chk("osc_en", {31'h0, ~cmd[1]}, {31'h0, osc_en});
    fire(bad);
    repeat (4) @(posedge clock);
    chk("core_run", 32'h0, {31'h0, core_run});
    fire(good);
    wt(1'b1, 1'b1);
    if (cmd[1]) chk("core_run", 32'h0, {31'h0, core_run});
    wt(1'b0, 1'b1);
  endtask : stby

  // ********************
  // result watcher and timeout
  // ********************
  always @(posedge clock) begin
    ret_seen <= core_ret;
    if (rsp.pready === 1'b1 && req.pwrite === 1'b0 && rd_q.size() > 0)
      chk("prdata", rd_q.pop_front(), rsp.prdata);
    if (ret_seen === 1'b1 && ret_q.size() > 0)
      chk("ret_pc", ret_q.pop_front(), {19'h0, ret_pc});
    if (irq_pulse === 1'b1)
      chk("irq_vec", irq_q.size() > 0 ? irq_q.pop_front() : 32'hF, {30'h0, irq_vec});
    cycles++;
    if (cycles > 20000) begin
      fails++;
      close_out();
    end
  end

  // main sequence
  initial begin
    logic [31:0] r;
    repeat (12) @(posedge clock);
    sys_rst <= 1'b0;
    for (int a = 0; a < 28; a += 4) rd(8'(a), 32'h0);
    chk("pslverr", 32'h1, {31'h0, last_err});
    for (int a = 4; a < 16; a += 4) begin
      r = xs();
      apb(1'b1, 8'(a), r);
      rd(8'(a), r & (a == 4 ? 32'h1F : a == 8 ? 32'hFF : 32'hF));
    end
    apb(1'b1, 8'h0C, 32'h0);
    for (int k = 0; k < 5; k++) begin
      apb(1'b1, 8'h04, 32'h1 << k);
      if (k == 0) fire(0);
      stby(32'h1, k == 0 ? 0 : k == 1 ? 3 : 1, k);
    end
    apb(1'b1, 8'h04, 32'h1F);
    for (int b = 1; b < 4; b++) begin
      fire(0);
      stby(32'h2, b, 0);
    end
    apb(1'b1, 8'h00, 32'h8);
    repeat (2) @(posedge clock);
    chk("force_in", 32'h1, {31'h0, force_in});
    rd(8'h00, 32'h8);
    stby(32'hA, 1, 2);
    apb(1'b1, 8'h04, 32'h10);
    stby(32'h1, 5, 4);
    stby(32'h5, 4, 5);
    apb(1'b1, 8'h04, 32'h0);
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, 8'h08, 32'h1 << i);
      stby(i % 2 ? 32'h2 : 32'h1, 8 + (i + 1) % 8, 8 + i);
    end
    // nine calls: the last one overflows and is dropped
    apb(1'b1, 8'h14, 32'h3F);
    for (int c = 0; c < 9; c++) begin
      pc_in <= 13'(xs());
      do_call <= 1'b1;
      @(posedge clock);
      do_call <= 1'b0;
      if (c < 8) ret_q.push_front({19'h0, pc_in});
      @(posedge clock);
    end
    rd(8'h14, 32'h10);
    rd(8'h10, 32'h20);
    for (int c = 0; c < 9; c++) begin
      do_ret <= 1'b1;
      @(posedge clock);
      do_ret <= 1'b0;
      @(posedge clock);
    end
    repeat (3) @(posedge clock);
    rd(8'h14, 32'h30);
    fire(0);
    apb(1'b1, 8'h14, 32'h3F);
    apb(1'b1, 8'h0C, 32'hF);
    for (int v = 0; v < 4; v++) begin
      irq_q.push_back(32'(v));
      // serial select is 0 here, so the shared factor comes from the serial pins
      fire(v == 3 ? 4 : v);
      repeat (6) @(posedge clock);
    end
    chk("irq_left", 32'h0, 32'(irq_q.size()));
    close_out();
  end
endmodule : swc_top_bench
